// ==== rtl/nvm_access_regs.svh ====
// Purpose: Addresses, bit positions, reset values and timing counts of the NVM access unit
// Assumes: 12-bit special-function register address space
// Notes:   Definitions only
`ifndef NVM_ACCESS_REGS_SVH
`define NVM_ACCESS_REGS_SVH

// Register addresses
`define ADDR_PERIPH_FLAG_TWO   12'hFA1
`define ADDR_MEM_ACCESS_CTRL   12'hFA6
`define ADDR_UNLOCK_PORT       12'hFA7
`define ADDR_EEPROM_DATA       12'hFA8
`define ADDR_EEPROM_ADDRESS    12'hFA9
`define ADDR_TABLE_LATCH       12'hFF5
`define ADDR_TBL_PTR_LOW       12'hFF6
`define ADDR_TBL_PTR_HIGH      12'hFF7
`define ADDR_TBL_PTR_UPPER     12'hFF8

// Control register fields, and the done bit of the peripheral flag register
`define BIT_PROG_OR_DATA       7
`define BIT_CONFIG_SELECT      6
`define BIT_CTRL_UNUSED        5
`define BIT_ROW_ERASE          4
`define BIT_WRITE_ABORT        3
`define BIT_WRITE_PERMIT       2
`define BIT_WRITE_START        1
`define BIT_READ_START         0
`define BIT_NVM_DONE           4

// Unlock sequence values
`define UNLOCK_FIRST           8'h55
`define UNLOCK_SECOND          8'hAA

// Block geometry (low pointer bits ignored)
`define WRITE_BLOCK_BITS       3
`define ERASE_ROW_BITS         6
`define HOLD_COUNT             8

// Reset values
`define RESET_BYTE             8'h00
`define RESET_HOLD_BYTE        8'hFF
`define NOP_WORD               16'h0000

// Self-timed write duration
`define NVM_WRITE_TIME_US      2000
`define NVM_CLK_MHZ            40

`endif

// ==== rtl/nvm_access_pkg.sv ====
// Purpose: Types of the NVM access unit
// Assumes: nvm_access_regs.svh for numeric constants
// Notes:   State of each module is one packed struct
package nvm_access_pkg;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_TBL_READ = 3'b010,
        ST_PROG     = 3'b100
    } fsm_t;

    typedef enum logic [1:0] {
        TBL_KEEP    = 2'b00,
        TBL_POSTINC = 2'b01,
        TBL_POSTDEC = 2'b10,
        TBL_PREINC  = 2'b11
    } tbl_mode_t;

    typedef enum logic [1:0] {
        TGT_EEPROM = 2'b00,
        TGT_FLASH  = 2'b01,
        TGT_CONFIG = 2'b10
    } target_t;

    typedef enum logic [1:0] {
        UNLOCK_NONE  = 2'b00,
        UNLOCK_HALF  = 2'b01,
        UNLOCK_ARMED = 2'b10
    } unlock_t;

    typedef struct packed {
        fsm_t        fsm;
        logic        prog_or_data_select;
        logic        config_space_select;
        logic        row_erase;
        logic        write_abort_error;
        logic        write_permit;
        logic        write_start;
        logic        read_start;
        logic [7:0]  table_byte_latch;
        logic [21:0] table_address_pointer;
        logic [7:0]  eeprom_data_reg;
        logic [7:0]  eeprom_address_reg;
        logic        nvm_done_flag;
        unlock_t     unlock;
        logic        op_erase;
        target_t     op_target;
        logic [21:0] op_addr;
        logic [31:0] timer;
        logic        read_high_byte;
        logic [21:0] flash_rd_addr;
        logic        flash_rd_en;
        logic [7:0]  sfr_rdata;
        logic        commit;
        logic [15:0] exec_word;
    } ctrl_state_t;

    typedef struct packed {
        logic [7:0][7:0] bytes;
    } hold_state_t;

endpackage

// ==== rtl/nvm_hold_if.sv ====
// Purpose: Carries holding-register traffic between control and holding bank
// Assumes: Single clock domain
// Notes:   No clocking block
`timescale 1ns/1ps
interface nvm_hold_if;
    logic        wr_en;
    logic [2:0]  idx;
    logic [7:0]  wr_byte;
    logic        clear;
    logic [63:0] block;

    modport ctrl (output wr_en, output idx, output wr_byte, output clear, input block);
    modport bank (input wr_en, input idx, input wr_byte, input clear, output block);
endinterface

// ==== rtl/nvm_hold_bank.sv ====
// Purpose: Eight byte holding registers for one program memory write block
// Assumes: Written one byte per table write, erased after each program or configuration write commit, not after an erase
// Notes:   Byte i sits in block bits 8*i+7 .. 8*i
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
module nvm_hold_bank
    import nvm_access_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Holding traffic
    nvm_hold_if.bank  hold
);
    hold_state_t st;
    hold_state_t next_st;

    always_comb begin
        next_st = st;
        if (hold.clear) begin
            for (int i = 0; i < `HOLD_COUNT; i++) begin
                next_st.bytes[i] = `RESET_HOLD_BYTE;
            end
        end else if (hold.wr_en) begin
            next_st.bytes[hold.idx] = hold.wr_byte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= {`HOLD_COUNT{`RESET_HOLD_BYTE}};
        end else begin
            st <= next_st;
        end
    end

    for (genvar g = 0; g < `HOLD_COUNT; g++) begin : g_block
        assign hold.block[8*g +: 8] = st.bytes[g];
    end
endmodule // nvm_hold_bank

// ==== rtl/program_memory_table_access.sv ====
// Purpose: Table read/write, row erase and self-timed write control for program flash and data EEPROM
// Assumes: Core presents SFR accesses and table operations synchronous to core_clk
// Notes:   power_on_reset clears everything; reset keeps select and abort bits, setting abort if a write is running
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
module program_memory_table_access
    import nvm_access_pkg::*;
#(
    parameter int WRITE_CYCLES = `NVM_WRITE_TIME_US * `NVM_CLK_MHZ
) (
    // Clock and resets
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        power_on_reset,
    // SFR access from the core
    input  wire logic [11:0] sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // Table operations from the core
    input  wire logic        tbl_valid,
    input  wire logic        tbl_write,
    input  wire logic [1:0]  tbl_mode,
    output logic             tbl_ready,
    // Instruction fetch path
    input  wire logic [15:0] fetch_word,
    input  wire logic        fetch_word_valid,
    output logic      [15:0] exec_word,
    output logic             fetch_stall,
    // Program memory array
    output logic      [21:1] flash_rd_addr,
    output logic             flash_rd_en,
    input  wire logic [15:0] flash_rd_data,
    output logic             prog_active,
    output logic             prog_erase,
    output logic      [1:0]  prog_target,
    output logic      [21:0] prog_addr,
    output logic      [63:0] prog_data,
    output logic             prog_commit,
    // Data EEPROM array
    output logic             ee_rd_en,
    output logic      [7:0]  ee_addr,
    output logic      [7:0]  ee_wdata,
    input  wire logic [7:0]  ee_rd_data
);
    // Refuse a cycle count the timer cannot serve
    if (WRITE_CYCLES < 1) begin : g_bad_cycles
        $error("WRITE_CYCLES must be at least one");
    end

    localparam logic [31:0] LAST_TICK = 32'(WRITE_CYCLES - 1);

    ctrl_state_t st;
    ctrl_state_t next_st;
    nvm_hold_if  hold ();

    nvm_hold_bank u_hold_bank (
        .core_clk (core_clk),
        .reset    (power_on_reset),
        .hold     (hold.bank)
    );

    function automatic logic sfr_hit(input logic [11:0] a, input logic [11:0] target);
        return a == target;
    endfunction

    function automatic target_t select_target(input logic cfg, input logic pgd);
        if (cfg) begin
            return TGT_CONFIG;
        end
        return pgd ? TGT_FLASH : TGT_EEPROM;
    endfunction

    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
        logic [20:0] low;
        low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
        return {p[21], low};
    endfunction

    logic        wr_ctrl;
    logic        start_ok;
    logic        tbl_go;
    logic [21:0] tbl_addr;
    logic [7:0]  ctrl_image;
    logic [7:0]  rd_mux;
    target_t     cur_target;
    tbl_mode_t   mode;

    always_comb begin
        mode       = tbl_mode_t'(tbl_mode);
        cur_target = select_target(st.config_space_select, st.prog_or_data_select);
        wr_ctrl    = sfr_wr && sfr_hit(sfr_addr, `ADDR_MEM_ACCESS_CTRL);
        start_ok   = wr_ctrl && sfr_wdata[`BIT_WRITE_START] && !st.write_start
                     && st.write_permit && st.unlock == UNLOCK_ARMED && st.fsm == ST_IDLE;
        tbl_go     = tbl_valid && st.fsm == ST_IDLE;
        tbl_addr   = (mode == TBL_PREINC) ? ptr_step(st.table_address_pointer, 1'b1)
                                          : st.table_address_pointer;
        ctrl_image = 8'h00;
        ctrl_image[`BIT_PROG_OR_DATA]  = st.prog_or_data_select;
        ctrl_image[`BIT_CONFIG_SELECT] = st.config_space_select;
        ctrl_image[`BIT_CTRL_UNUSED]   = 1'b0;
        ctrl_image[`BIT_ROW_ERASE]     = st.row_erase;
        ctrl_image[`BIT_WRITE_ABORT]   = st.write_abort_error;
        ctrl_image[`BIT_WRITE_PERMIT]  = st.write_permit;
        ctrl_image[`BIT_WRITE_START]   = st.write_start;
        ctrl_image[`BIT_READ_START]    = st.read_start;
        case (sfr_addr)
            `ADDR_MEM_ACCESS_CTRL: rd_mux = ctrl_image;
            `ADDR_UNLOCK_PORT:     rd_mux = 8'h00;
            `ADDR_EEPROM_DATA:     rd_mux = st.eeprom_data_reg;
            `ADDR_EEPROM_ADDRESS:  rd_mux = st.eeprom_address_reg;
            `ADDR_TABLE_LATCH:     rd_mux = st.table_byte_latch;
            `ADDR_TBL_PTR_LOW:     rd_mux = st.table_address_pointer[7:0];
            `ADDR_TBL_PTR_HIGH:    rd_mux = st.table_address_pointer[15:8];
            `ADDR_TBL_PTR_UPPER:   rd_mux = {2'b00, st.table_address_pointer[21:16]};
            `ADDR_PERIPH_FLAG_TWO: rd_mux = 8'(st.nvm_done_flag) << `BIT_NVM_DONE;
            default:               rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.commit      = 1'b0;
        next_st.flash_rd_en = 1'b0;
        next_st.sfr_rdata   = sfr_rd ? rd_mux : st.sfr_rdata;
        next_st.exec_word   = fetch_word_valid ? fetch_word : `NOP_WORD;
        hold.wr_en   = 1'b0;
        hold.idx     = st.table_address_pointer[`WRITE_BLOCK_BITS-1:0];
        hold.wr_byte = st.table_byte_latch;
        hold.clear   = 1'b0;

        // Unlock tracking: any other SFR write breaks the sequence
        if (sfr_wr) begin
            if (sfr_hit(sfr_addr, `ADDR_UNLOCK_PORT) && sfr_wdata == `UNLOCK_FIRST) begin
                next_st.unlock = UNLOCK_HALF;
            end else if (sfr_hit(sfr_addr, `ADDR_UNLOCK_PORT) && sfr_wdata == `UNLOCK_SECOND
                         && st.unlock == UNLOCK_HALF) begin
                next_st.unlock = UNLOCK_ARMED;
            end else begin
                next_st.unlock = UNLOCK_NONE;
            end
        end

        // Plain register writes
        if (wr_ctrl) begin
            next_st.prog_or_data_select = sfr_wdata[`BIT_PROG_OR_DATA];
            next_st.config_space_select = sfr_wdata[`BIT_CONFIG_SELECT];
            next_st.row_erase           = sfr_wdata[`BIT_ROW_ERASE];
            next_st.write_abort_error   = sfr_wdata[`BIT_WRITE_ABORT];
            next_st.write_permit        = sfr_wdata[`BIT_WRITE_PERMIT];
            if (sfr_wdata[`BIT_READ_START] && !st.prog_or_data_select) begin
                next_st.read_start = 1'b1;
            end
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_EEPROM_DATA)) begin
            next_st.eeprom_data_reg = sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_EEPROM_ADDRESS)) begin
            next_st.eeprom_address_reg = sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_TABLE_LATCH)) begin
            next_st.table_byte_latch = sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_TBL_PTR_LOW)) begin
            next_st.table_address_pointer[7:0] = sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_TBL_PTR_HIGH)) begin
            next_st.table_address_pointer[15:8] = sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_TBL_PTR_UPPER)) begin
            next_st.table_address_pointer[21:16] = sfr_wdata[5:0];
        end
        if (sfr_wr && sfr_hit(sfr_addr, `ADDR_PERIPH_FLAG_TWO)) begin
            next_st.nvm_done_flag = sfr_wdata[`BIT_NVM_DONE];
        end

        // One-cycle EEPROM read
        if (st.read_start) begin
            next_st.eeprom_data_reg = ee_rd_data;
            next_st.read_start      = 1'b0;
        end

        case (st.fsm)
            ST_IDLE: begin
                if (start_ok) begin
                    next_st.write_start = 1'b1;
                    next_st.unlock      = UNLOCK_NONE;
                    next_st.op_target   = cur_target;
                    next_st.op_erase    = st.row_erase && cur_target != TGT_EEPROM;
                    next_st.timer       = 32'h0000_0000;
                    next_st.fsm         = ST_PROG;
                    if (st.row_erase) begin
                        next_st.op_addr = {st.table_address_pointer[21:`ERASE_ROW_BITS],
                                           `ERASE_ROW_BITS'(0)};
                    end else begin
                        next_st.op_addr = {st.table_address_pointer[21:`WRITE_BLOCK_BITS],
                                           `WRITE_BLOCK_BITS'(0)};
                    end
                end else if (tbl_go) begin
                    if (tbl_write) begin
                        hold.wr_en = 1'b1;
                    end else begin
                        next_st.flash_rd_addr  = tbl_addr;
                        next_st.flash_rd_en    = 1'b1;
                        next_st.read_high_byte = tbl_addr[0];
                        next_st.fsm            = ST_TBL_READ;
                    end
                    case (mode)
                        TBL_POSTINC: next_st.table_address_pointer = ptr_step(st.table_address_pointer, 1'b1);
                        TBL_POSTDEC: next_st.table_address_pointer = ptr_step(st.table_address_pointer, 1'b0);
                        TBL_PREINC:  next_st.table_address_pointer = tbl_addr;
                        default:     next_st.table_address_pointer = st.table_address_pointer;
                    endcase
                end
            end
            ST_TBL_READ: begin
                next_st.table_byte_latch = st.read_high_byte ? flash_rd_data[15:8]
                                                             : flash_rd_data[7:0];
                next_st.fsm = ST_IDLE;
            end
            ST_PROG: begin
                next_st.timer = st.timer + 32'h0000_0001;
                if (st.timer == LAST_TICK) begin
                    next_st.write_start   = 1'b0;
                    next_st.nvm_done_flag = 1'b1;
                    next_st.commit        = 1'b1;
                    next_st.fsm           = ST_IDLE;
                    if (st.op_erase) begin
                        next_st.row_erase = 1'b0;
                    end else if (st.op_target != TGT_EEPROM) begin
                        hold.clear = 1'b1;
                    end
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (power_on_reset) begin
            st       <= '0;
            st.fsm   <= ST_IDLE;
            st.unlock <= UNLOCK_NONE;
            st.op_target <= TGT_EEPROM;
            st.exec_word <= `NOP_WORD;
        end else if (reset) begin
            st       <= '0;
            st.fsm   <= ST_IDLE;
            st.unlock <= UNLOCK_NONE;
            st.op_target <= TGT_EEPROM;
            st.exec_word <= `NOP_WORD;
            st.prog_or_data_select <= st.prog_or_data_select;
            st.config_space_select <= st.config_space_select;
            st.write_abort_error   <= st.write_abort_error || st.fsm == ST_PROG;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata     = st.sfr_rdata;
    assign tbl_ready     = st.fsm == ST_IDLE && !start_ok;
    assign exec_word     = st.exec_word;
    assign fetch_stall   = st.fsm == ST_PROG && st.op_target != TGT_EEPROM;
    assign flash_rd_addr = st.flash_rd_addr[21:1];
    assign flash_rd_en   = st.flash_rd_en;
    assign prog_active   = st.fsm == ST_PROG;
    assign prog_erase    = st.op_erase;
    assign prog_target   = st.op_target;
    assign prog_addr     = st.op_addr;
    assign prog_data     = hold.block;
    assign prog_commit   = st.commit;
    assign ee_rd_en      = st.read_start;
    assign ee_addr       = st.eeprom_address_reg;
    assign ee_wdata      = st.eeprom_data_reg;
endmodule // program_memory_table_access

// ==== sim/nvm_access_monitor.sv ====
// Purpose: Port checks of the NVM access unit
// Assumes: One clock, both resets synchronous
// Notes:   Bound to program_memory_table_access
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
module nvm_access_monitor (
    // Clock and resets
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        power_on_reset,
    // Core side
    input wire logic [11:0] sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        tbl_valid,
    input wire logic        tbl_write,
    input wire logic        tbl_ready,
    input wire logic [15:0] fetch_word,
    input wire logic        fetch_word_valid,
    input wire logic [15:0] exec_word,
    input wire logic        fetch_stall,
    // Array side
    input wire logic        flash_rd_en,
    input wire logic        prog_active,
    input wire logic        prog_erase,
    input wire logic [1:0]  prog_target,
    input wire logic [21:0] prog_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset || power_on_reset);

    AST_TBL_READ: assert property (tbl_valid && tbl_ready && !tbl_write |=> flash_rd_en && !tbl_ready ##1 !flash_rd_en)
        else $error("table read handshake wrong");
    AST_STALL: assert property (prog_active && prog_target != 2'h0 |-> fetch_stall)
        else $error("fetch not stalled during array cycle");
    AST_NOP_EXEC: assert property (!fetch_word_valid |=> exec_word == 16'h0000)
        else $error("invalid word not turned into no-op");
    AST_EXEC_PASS: assert property (fetch_word_valid && !reset && !power_on_reset |=> exec_word == $past(fetch_word))
        else $error("valid word not passed on");
    AST_ROW_ALIGN: assert property (prog_active && prog_erase |-> prog_addr[5:0] == 6'h00)
        else $error("erase row address not aligned");
    AST_BLOCK_ALIGN: assert property (prog_active && !prog_erase && prog_target != 2'h0 |-> prog_addr[2:0] == 3'h0)
        else $error("write block address not aligned");
    AST_UNLOCK_ZERO: assert property (sfr_rd && sfr_addr == `ADDR_UNLOCK_PORT |=> sfr_rdata == 8'h00)
        else $error("unlock port read not zero");
    AST_SPARE_BIT: assert property (sfr_rd && sfr_addr == `ADDR_MEM_ACCESS_CTRL |=> !sfr_rdata[5])
        else $error("spare control bit read as one");
    AST_START_CAUSE: assert property ($rose(prog_active) |-> $past(sfr_wr && sfr_addr == `ADDR_MEM_ACCESS_CTRL && sfr_wdata[1]))
        else $error("array cycle began without start write");
endmodule // nvm_access_monitor

bind program_memory_table_access nvm_access_monitor nvm_access_monitor_inst (
    .core_clk(core_clk), .reset(reset), .power_on_reset(power_on_reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
    .tbl_ready(tbl_ready), .fetch_word(fetch_word), .fetch_word_valid(fetch_word_valid), .exec_word(exec_word),
    .fetch_stall(fetch_stall), .flash_rd_en(flash_rd_en), .prog_active(prog_active), .prog_erase(prog_erase),
    .prog_target(prog_target), .prog_addr(prog_addr));

// ==== sim/nvm_array_model.sv ====
// Purpose: Program flash and data EEPROM read ports
// Assumes: Contents are a fixed function of address
// Notes:   Read data goes stale outside its window
`timescale 1ns/1ps
module nvm_array_model (
    // Clock
    input wire logic        core_clk,
    // Flash read port
    input wire logic [21:1] flash_rd_addr,
    input wire logic        flash_rd_en,
    output logic     [15:0] flash_rd_data,
    // EEPROM read port
    input wire logic [7:0]  ee_addr,
    input wire logic        ee_rd_en,
    output logic     [7:0]  ee_rd_data
);
    logic        rd_seen = 1'b0;
    logic [15:0] word_held = 16'h0000;

    function automatic logic [15:0] flash_word(input logic [21:1] a);
        return {a[8:1] ^ 8'h5A, a[16:9]};
    endfunction

    always_ff @(posedge core_clk) begin
        rd_seen <= flash_rd_en;
        if (flash_rd_en) begin
            word_held <= flash_word(flash_rd_addr);
        end
    end
    // One 16-bit word per access, held for the pulse and the cycle after
    assign flash_rd_data = flash_rd_en ? flash_word(flash_rd_addr) : rd_seen ? word_held : ~word_held;
    assign ee_rd_data    = ee_rd_en ? (ee_addr ^ 8'hC3) : ~(ee_addr ^ 8'hC3);
endmodule // nvm_array_model

// ==== sim/tb.sv ====
// Purpose: Self-checking bench of the NVM access unit
// Assumes: Array model answers reads
// Notes:   Self-timed cycle shortened to 8 clocks
`timescale 1ns/1ps
`include "nvm_access_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
    localparam logic [11:0] CTL = `ADDR_MEM_ACCESS_CTRL;
    localparam logic [11:0] KEY = `ADDR_UNLOCK_PORT;
    localparam logic [11:0] FLG = `ADDR_PERIPH_FLAG_TWO;
    localparam logic [11:0] LAT = `ADDR_TABLE_LATCH;
    logic        core_clk = 1'b0, reset = 1'b1, power_on_reset = 1'b1;
    logic [11:0] sfr_addr = 12'h000;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0, tbl_valid = 1'b0, tbl_write = 1'b0, fetch_word_valid = 1'b0;
    logic [1:0]  tbl_mode = 2'h0;
    logic [15:0] fetch_word = 16'h0000;
    logic [7:0]  sfr_rdata, ee_addr, ee_wdata, ee_rd_data, exp_now;
    logic [15:0] exec_word, flash_rd_data;
    logic [21:1] flash_rd_addr;
    logic [21:0] prog_addr;
    logic [63:0] prog_data;
    logic [1:0]  prog_target;
    logic        tbl_ready, fetch_stall, flash_rd_en, prog_active, prog_erase, prog_commit, ee_rd_en;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    int          mismatches = 0;
    int          comparisons = 0;

    always #12.5 core_clk = ~core_clk;

    program_memory_table_access #(.WRITE_CYCLES(8)) program_memory_table_access_inst (
        .core_clk(core_clk), .reset(reset), .power_on_reset(power_on_reset), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tbl_valid(tbl_valid),
        .tbl_write(tbl_write), .tbl_mode(tbl_mode), .tbl_ready(tbl_ready), .fetch_word(fetch_word),
        .fetch_word_valid(fetch_word_valid), .exec_word(exec_word), .fetch_stall(fetch_stall),
        .flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data),
        .prog_active(prog_active), .prog_erase(prog_erase), .prog_target(prog_target), .prog_addr(prog_addr),
        .prog_data(prog_data), .prog_commit(prog_commit), .ee_rd_en(ee_rd_en), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_rd_data(ee_rd_data));
    nvm_array_model nvm_array_model_inst (
        .core_clk(core_clk), .flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en),
        .flash_rd_data(flash_rd_data), .ee_addr(ee_addr), .ee_rd_en(ee_rd_en), .ee_rd_data(ee_rd_data));

    // Random fetch stream; register reads checked against oldest note
    always @(posedge core_clk) begin
        fetch_word <= 16'($urandom);
        fetch_word_valid <= 1'($urandom);
        rd_seen <= sfr_rd;
        if (rd_seen) begin
            exp_now = exp_q.pop_front();
            `CHK("sfr_rdata", exp_now, sfr_rdata)
        end
    end

    task automatic wrap_up;
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask

    task automatic setptr(input logic [21:0] p);
        wr(`ADDR_TBL_PTR_LOW, p[7:0]);
        wr(`ADDR_TBL_PTR_HIGH, p[15:8]);
        wr(`ADDR_TBL_PTR_UPPER, {2'b00, p[21:16]});
    endtask

    task automatic wait_on(input logic lvl);
        int n;
        n = 0;
        while (prog_active !== lvl && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        if (prog_active !== lvl) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic tbl(input logic w, input logic [1:0] m);
        int n;
        n = 0;
        @(posedge core_clk);
        tbl_valid <= 1'b1;
        tbl_write <= w;
        tbl_mode <= m;
        do begin
            @(posedge core_clk);
            n++;
        end while (tbl_ready !== 1'b1 && n < 20);
        tbl_valid <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
        @(posedge core_clk);
    endtask

    // Unlocked start, then wait for the array cycle
    task automatic go(input logic [7:0] c);
        wr(CTL, c);
        wr(KEY, 8'h55);
        wr(KEY, 8'hAA);
        wr(CTL, c | 8'h02);
        wait_on(1'b1);
    endtask

    function automatic logic [7:0] fbyte(input logic [21:0] a);
        return a[0] ? (a[8:1] ^ 8'h5A) : a[16:9];
    endfunction

    initial begin
        logic [21:0] p;
        logic [21:0] np;
        logic [7:0]  d;
        logic [63:0] blk;
        void'($urandom(43));
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        rd(CTL, 8'h00);
        rd(KEY, 8'h00);
        rd(12'h123, 8'h00);
        wr(CTL, 8'hFF);
        rd(CTL, 8'hDC);
        wr(CTL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            p = 22'($urandom);
            np = {p[21], p[20:0] + 21'(i % 2) - 21'(i == 2)};
            setptr(p);
            tbl(1'b0, 2'(i));
            rd(LAT, fbyte(i == 3 ? np : p));
            rd(`ADDR_TBL_PTR_LOW, np[7:0]);
        end
        p = {2'b00, 17'($urandom), 3'h5};
        setptr(p);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            blk[8 * ((i + 5) % 8) +: 8] = d;
            wr(LAT, d);
            tbl(1'b1, 2'h1);
        end
        np = {p[21:3] + 19'h1, 3'h0};
        go(8'h84);
        `CHK("prog_data", blk, prog_data)
        `CHK("prog_addr", np, prog_addr)
        `CHK("prog_target", 2'h1, prog_target)
        `CHK("fetch_stall", 1'b1, fetch_stall)
        wait_on(1'b0);
        `CHK("prog_commit", 1'b1, prog_commit)
        rd(CTL, 8'h84);
        rd(FLG, 8'h10);
        wr(FLG, 8'h00);
        rd(FLG, 8'h00);
        p = 22'($urandom);
        setptr(p);
        np = {p[21:6], 6'h00};
        go(8'h94);
        `CHK("prog_addr", np, prog_addr)
        `CHK("prog_erase", 1'b1, prog_erase)
        wait_on(1'b0);
        rd(CTL, 8'h84);
        wr(FLG, 8'h00);
        wr(CTL, 8'h86);
        wr(KEY, 8'h55);
        wr(FLG, 8'h00);
        wr(KEY, 8'hAA);
        wr(CTL, 8'h86);
        wr(CTL, 8'h80);
        wr(KEY, 8'h55);
        wr(KEY, 8'hAA);
        wr(CTL, 8'h82);
        repeat (12) @(posedge core_clk);
        rd(FLG, 8'h00);
        d = 8'($urandom) | 8'h04;
        wr(`ADDR_EEPROM_ADDRESS, d);
        wr(CTL, 8'h00);
        wr(CTL, 8'h01);
        rd(`ADDR_EEPROM_DATA, d ^ 8'hC3);
        `CHK("ee_wdata", d ^ 8'hC3, ee_wdata)
        rd(CTL, 8'h00);
        go(8'h04);
        `CHK("fetch_stall", 1'b0, fetch_stall)
        `CHK("prog_target", 2'h0, prog_target)
        wait_on(1'b0);
        go(8'hC4);
        `CHK("prog_target", 2'h2, prog_target)
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        rd(CTL, 8'hC8);
        rd(`ADDR_EEPROM_DATA, 8'h00);
        rd(`ADDR_EEPROM_ADDRESS, 8'h00);
        repeat (3) @(posedge core_clk);
        wrap_up();
    end
endmodule // tb
